// ### rtl/bmt_regs.svh
// Register offsets, field positions and constants of the bus memory and I/O test engine.
// Assumes an 8-bit byte address on the register port, one 32-bit word per register.
`ifndef BMT_REGS_SVH
`define BMT_REGS_SVH

`define OFS_CTRL 8'h00
`define OFS_LOADDR 8'h04
`define OFS_HIADDR 8'h08
`define OFS_MASK 8'h0c
`define OFS_EXPSIG 8'h10
`define OFS_STAT 8'h14
`define OFS_ERRADDR 8'h18
`define OFS_ERRWORD 8'h1c
`define OFS_SIGVAL 8'h20

`define CTRL_START 0
`define CTRL_SEL 2:1
`define CTRL_LOOP 3
`define CTRL_STOP 4

`define STAT_BUSY 0
`define STAT_DONE 1
`define STAT_PASS 2
`define STAT_ERR 3
`define STAT_LOOPING 4
`define STAT_OK 5
`define STAT_REJ 6
`define STAT_KIND 11:8

`define ALL_ONES 32'hffffffff
`define SIG_POLY 16'h1021
`define SIG_SEED 16'h0000
`define SIG_MAX 32'h0000ffff

`endif

// ### rtl/bmt_pkg.sv
// Types of the test engine: test selection, error kinds and sequencer states.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package bmt_pkg;
  typedef enum logic [1:0] {TEST_IO = 2'b00, TEST_ROM = 2'b01, TEST_RAM = 2'b10} test_e;
  typedef enum logic [3:0] {
    ERR_NONE = 4'h0, ERR_IO = 4'h1, ERR_ROM = 4'h2, ERR_RAMRW = 4'h3, ERR_TIED = 4'h4, ERR_DC = 4'h5
  } errkind_e;
  typedef enum logic [4:0] {
    S_IDLE = 5'b00000, S_RW_W1 = 5'b00001, S_RW_R1 = 5'b00010, S_RW_W0 = 5'b00011,
    S_RW_R0 = 5'b00100, S_RW_CHK = 5'b00101, S_ROM_RD = 5'b00110, S_ROM_WT = 5'b00111,
    S_ROM_CHK = 5'b01000, S_TD_W1 = 5'b01001, S_TD_R1 = 5'b01010, S_TD_W2 = 5'b01011,
    S_TD_R2 = 5'b01100, S_TD_CHK = 5'b01101, S_DC_SEL = 5'b01110, S_DC_W1 = 5'b01111,
    S_DC_W0 = 5'b10000, S_DC_RD = 5'b10001, S_DC_CHK = 5'b10010, S_DONE = 5'b10011
  } state_e;
endpackage : bmt_pkg
`default_nettype wire

// ### rtl/sig_if.sv
// Carrier between the test sequencer and the signature compressor.
// Assumes both ends run on core_clk.
`default_nettype none
interface sig_if;
  logic clr;
  logic en;
  logic [31:0] data;
  logic [15:0] sig;
  modport src (output clr, output en, output data, input sig);
  modport lfsr (input clr, input en, input data, output sig);
endinterface : sig_if
`default_nettype wire

// ### rtl/sig_lfsr.sv
// Sixteen-bit signature compressor fed one 32-bit word per enable.
// Assumes clear and enable are one-cycle pulses on core_clk.
`include "bmt_regs.svh"
`default_nettype none
module sig_lfsr (
  input wire logic core_clk,
  input wire logic srst,
  sig_if.lfsr sp
);
  logic [15:0] sig_ff;

  function automatic logic [15:0] sigStep(input logic [15:0] s, input logic [31:0] d);
    logic [15:0] t;
    logic fb;
    t = s;
    for (int k = 31; k >= 0; k--)
    begin
      fb = t[15] ^ d[k];
      t = {t[14:0], 1'b0} ^ (fb ? `SIG_POLY : 16'h0000);
    end
    return t;
  endfunction : sigStep

  always_ff @(posedge core_clk)
  begin
    if (srst || sp.clr)
      sig_ff <= `SIG_SEED;
    else if (sp.en)
      sig_ff <= sigStep(sig_ff, sp.data);
  end

  assign sp.sig = sig_ff;
endmodule : sig_lfsr
`default_nettype wire

// ### rtl/bus_memory_io_test_engine.sv
// Bus memory and I/O test engine: I/O, ROM signature and short RAM tests on a target bus.
// Assumes a target adapter that answers each held read or write request with tgtAck.
`include "bmt_regs.svh"
`default_nettype none
module bus_memory_io_test_engine
  import bmt_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  output logic [31:0] tgtAddr,
  output logic [31:0] tgtWdata,
  output logic tgtWr,
  output logic tgtRd,
  input wire logic tgtAck,
  input wire logic [31:0] tgtRdata
);
  logic [31:0] lo_ff, hi_ff, mask_ff, eaddr_ff, eword_ff, addr_ff, rdat_ff, rd1_ff;
  logic [31:0] regRdata_ff, tgtAddr_ff, tgtWdata_ff, sigData_ff;
  logic [15:0] expSig_ff;
  logic [4:0] bi_ff, bj_ff;
  logic tgtWr_ff, tgtRd_ff, reqOn_ff, sigClr_ff, sigEn_ff, loopEn_ff;
  logic busy_ff, done_ff, pass_ff, errSeen_ff, okEvt_ff, rej_ff, looping_ff, unres_ff;
  logic repErr_ff, repOk_ff;
  test_e test_ff;
  errkind_e kind_ff;
  state_e st_ff;

  logic wrCtrl, wrStat, startReq, stopReq, badStart, goRun, sigBad;
  logic accWr, accRd, isChk, errNow, again, giveUp, unresNow;
  logic [31:0] accAddr, accData, rwMask, rwErr, dcHigh, ewordNow, rdMux;
  logic tdErr;
  state_e nxtSt;
  errkind_e kindNow;
  test_e selTest;

  sig_if sigIf();

  sig_lfsr uSig (
    .core_clk(core_clk),
    .srst(srst),
    .sp(sigIf.lfsr)
  );

  assign sigIf.clr = sigClr_ff;
  assign sigIf.en = sigEn_ff;
  assign sigIf.data = sigData_ff;

  function automatic logic [31:0] bitOf(input logic [4:0] idx);
    bitOf = 32'h00000001 << idx;
  endfunction : bitOf

  assign wrCtrl = regWr && (regAddr == `OFS_CTRL);
  assign wrStat = regWr && (regAddr == `OFS_STAT);
  assign startReq = wrCtrl && regWdata[`CTRL_START];
  assign stopReq = wrCtrl && regWdata[`CTRL_STOP];
  assign selTest = test_e'(regWdata[`CTRL_SEL]);
  assign badStart = ((selTest == TEST_IO) && (mask_ff == 32'h00000000)) || (hi_ff < lo_ff)
                    || (selTest != TEST_IO && selTest != TEST_ROM && selTest != TEST_RAM);
  assign goRun = startReq && !busy_ff && !badStart;
  assign sigBad = regWr && (regAddr == `OFS_EXPSIG) && (regWdata > `SIG_MAX);

  assign rwMask = (test_ff == TEST_IO) ? mask_ff : `ALL_ONES;
  assign rwErr = ((~rd1_ff) | rdat_ff) & rwMask;
  assign tdErr = !rd1_ff[bi_ff] || rd1_ff[bj_ff] || !rdat_ff[bj_ff] || rdat_ff[bi_ff];
  assign dcHigh = lo_ff | bitOf(bi_ff);

  always_comb
  begin
    accWr = 1'b0;
    accRd = 1'b0;
    accAddr = addr_ff;
    accData = 32'h00000000;
    nxtSt = st_ff;
    unique case (st_ff)
      S_RW_W1:
      begin
        accWr = 1'b1;
        accData = rwMask;
        nxtSt = S_RW_R1;
      end
      S_RW_R1:
      begin
        accRd = 1'b1;
        nxtSt = S_RW_W0;
      end
      S_RW_W0:
      begin
        accWr = 1'b1;
        nxtSt = S_RW_R0;
      end
      S_RW_R0:
      begin
        accRd = 1'b1;
        nxtSt = S_RW_CHK;
      end
      S_ROM_RD:
      begin
        accRd = 1'b1;
      end
      S_TD_W1:
      begin
        accWr = 1'b1;
        accAddr = lo_ff;
        accData = bitOf(bi_ff);
        nxtSt = S_TD_R1;
      end
      S_TD_R1:
      begin
        accRd = 1'b1;
        accAddr = lo_ff;
        nxtSt = S_TD_W2;
      end
      S_TD_W2:
      begin
        accWr = 1'b1;
        accAddr = lo_ff;
        accData = bitOf(bj_ff);
        nxtSt = S_TD_R2;
      end
      S_TD_R2:
      begin
        accRd = 1'b1;
        accAddr = lo_ff;
        nxtSt = S_TD_CHK;
      end
      S_DC_W1:
      begin
        accWr = 1'b1;
        accAddr = dcHigh;
        accData = `ALL_ONES;
        nxtSt = S_DC_W0;
      end
      S_DC_W0:
      begin
        accWr = 1'b1;
        accAddr = lo_ff;
        nxtSt = S_DC_RD;
      end
      S_DC_RD:
      begin
        accRd = 1'b1;
        accAddr = dcHigh;
        nxtSt = S_DC_CHK;
      end
      default:
      begin
        nxtSt = st_ff;
      end
    endcase
  end

  always_comb
  begin
    isChk = 1'b1;
    errNow = 1'b0;
    kindNow = ERR_NONE;
    ewordNow = 32'h00000000;
    unique case (st_ff)
      S_RW_CHK:
      begin
        errNow = (rwErr != 32'h00000000);
        kindNow = (test_ff == TEST_IO) ? ERR_IO : ERR_RAMRW;
        ewordNow = rwErr;
      end
      S_ROM_CHK:
      begin
        errNow = (sigIf.sig != expSig_ff);
        kindNow = ERR_ROM;
        ewordNow = {16'h0000, sigIf.sig};
      end
      S_TD_CHK:
      begin
        errNow = tdErr;
        kindNow = ERR_TIED;
        ewordNow = {19'h00000, bj_ff, 3'h0, bi_ff};
      end
      S_DC_CHK:
      begin
        errNow = (rdat_ff != `ALL_ONES);
        kindNow = ERR_DC;
        ewordNow = {27'h0000000, bi_ff};
      end
      default:
      begin
        isChk = 1'b0;
      end
    endcase
  end

  assign again = isChk && errNow && (looping_ff || loopEn_ff);
  assign giveUp = isChk && errNow && !looping_ff && !loopEn_ff;
  assign unresNow = unres_ff || giveUp;

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      st_ff <= S_IDLE;
      reqOn_ff <= 1'b0;
      tgtWr_ff <= 1'b0;
      tgtRd_ff <= 1'b0;
      tgtAddr_ff <= 32'h00000000;
      tgtWdata_ff <= 32'h00000000;
      addr_ff <= 32'h00000000;
      bi_ff <= 5'h00;
      bj_ff <= 5'h01;
      rdat_ff <= 32'h00000000;
      rd1_ff <= 32'h00000000;
      sigClr_ff <= 1'b0;
      sigEn_ff <= 1'b0;
      sigData_ff <= 32'h00000000;
    end
    else
    begin
      sigClr_ff <= 1'b0;
      sigEn_ff <= 1'b0;
      if (stopReq && st_ff != S_IDLE)
      begin
        st_ff <= S_DONE;
        reqOn_ff <= 1'b0;
        tgtWr_ff <= 1'b0;
        tgtRd_ff <= 1'b0;
      end
      else if (accWr || accRd)
      begin
        if (!reqOn_ff)
        begin
          reqOn_ff <= 1'b1;
          tgtWr_ff <= accWr;
          tgtRd_ff <= accRd;
          tgtAddr_ff <= accAddr;
          tgtWdata_ff <= accData;
        end
        else if (tgtAck)
        begin
          reqOn_ff <= 1'b0;
          tgtWr_ff <= 1'b0;
          tgtRd_ff <= 1'b0;
          if (tgtRd_ff)
          begin
            rdat_ff <= tgtRdata;
            rd1_ff <= rdat_ff;
          end
          if (st_ff == S_ROM_RD)
          begin
            sigEn_ff <= 1'b1;
            sigData_ff <= tgtRdata;
            if (addr_ff == hi_ff)
              st_ff <= S_ROM_WT;
            else
              addr_ff <= addr_ff + 32'h00000001;
          end
          else
            st_ff <= nxtSt;
        end
      end
      else
      begin
        unique case (st_ff)
          S_IDLE:
          begin
            if (goRun)
            begin
              addr_ff <= lo_ff;
              bi_ff <= 5'h00;
              bj_ff <= 5'h01;
              sigClr_ff <= (selTest == TEST_ROM);
              st_ff <= (selTest == TEST_ROM) ? S_ROM_RD : S_RW_W1;
            end
          end
          S_ROM_WT:
            st_ff <= S_ROM_CHK;
          S_RW_CHK:
          begin
            if (again)
              st_ff <= S_RW_W1;
            else if (addr_ff != hi_ff)
            begin
              addr_ff <= addr_ff + 32'h00000001;
              st_ff <= S_RW_W1;
            end
            else if (test_ff == TEST_IO || unresNow)
              st_ff <= S_DONE;
            else
              st_ff <= S_TD_W1;
          end
          S_ROM_CHK:
          begin
            if (again)
            begin
              addr_ff <= lo_ff;
              sigClr_ff <= 1'b1;
              st_ff <= S_ROM_RD;
            end
            else
              st_ff <= S_DONE;
          end
          S_TD_CHK:
          begin
            if (again)
              st_ff <= S_TD_W1;
            else if (bj_ff != 5'd31)
            begin
              bj_ff <= bj_ff + 5'd1;
              st_ff <= S_TD_W1;
            end
            else if (bi_ff != 5'd30)
            begin
              bi_ff <= bi_ff + 5'd1;
              bj_ff <= bi_ff + 5'd2;
              st_ff <= S_TD_W1;
            end
            else
            begin
              bi_ff <= 5'h00;
              st_ff <= unresNow ? S_DONE : S_DC_SEL;
            end
          end
          // Bits already set in the base or reaching past the block cannot be probed
          S_DC_SEL:
          begin
            if (!lo_ff[bi_ff] && dcHigh <= hi_ff)
              st_ff <= S_DC_W1;
            else if (bi_ff == 5'd31)
              st_ff <= S_DONE;
            else
              bi_ff <= bi_ff + 5'd1;
          end
          S_DC_CHK:
          begin
            if (again)
              st_ff <= S_DC_W1;
            else if (bi_ff == 5'd31)
              st_ff <= S_DONE;
            else
            begin
              bi_ff <= bi_ff + 5'd1;
              st_ff <= S_DC_SEL;
            end
          end
          S_DONE:
            st_ff <= S_IDLE;
          default:
            st_ff <= S_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      eaddr_ff <= 32'h00000000;
      eword_ff <= 32'h00000000;
      kind_ff <= ERR_NONE;
      repErr_ff <= 1'b0;
      repOk_ff <= 1'b0;
      looping_ff <= 1'b0;
      unres_ff <= 1'b0;
    end
    else
    begin
      repErr_ff <= isChk && errNow && !looping_ff;
      repOk_ff <= isChk && !errNow && looping_ff;
      if (isChk && errNow && !looping_ff)
      begin
        eaddr_ff <= (st_ff == S_RW_CHK) ? addr_ff : lo_ff;
        eword_ff <= ewordNow;
        kind_ff <= kindNow;
      end
      else if (isChk && !errNow && looping_ff && (st_ff == S_RW_CHK))
        eword_ff <= 32'h00000000;
      if (goRun || stopReq || (isChk && !errNow))
        looping_ff <= 1'b0;
      else if (isChk && errNow && loopEn_ff)
        looping_ff <= 1'b1;
      if (goRun)
        unres_ff <= 1'b0;
      else if (giveUp || (stopReq && busy_ff))
        unres_ff <= 1'b1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      pass_ff <= 1'b0;
      errSeen_ff <= 1'b0;
      okEvt_ff <= 1'b0;
      rej_ff <= 1'b0;
    end
    else
    begin
      if (goRun)
        busy_ff <= 1'b1;
      else if (st_ff == S_DONE)
        busy_ff <= 1'b0;
      if (st_ff == S_DONE)
        pass_ff <= !unres_ff;
      else if (goRun)
        pass_ff <= 1'b0;
      // Set wins over a write-one clear in the same cycle
      done_ff <= (st_ff == S_DONE) || (done_ff && !(wrStat && regWdata[`STAT_DONE]));
      errSeen_ff <= repErr_ff || (errSeen_ff && !(wrStat && regWdata[`STAT_ERR]));
      okEvt_ff <= repOk_ff || (okEvt_ff && !(wrStat && regWdata[`STAT_OK]));
      rej_ff <= (startReq && !busy_ff && badStart) || sigBad || (rej_ff && !(wrStat && regWdata[`STAT_REJ]));
    end
  end

  // Block bounds are frozen while a run is in flight
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      lo_ff <= 32'h00000000;
      hi_ff <= 32'h00000000;
      mask_ff <= 32'h00000000;
      expSig_ff <= 16'h0000;
      test_ff <= TEST_IO;
      loopEn_ff <= 1'b0;
    end
    else
    begin
      if (wrCtrl)
        loopEn_ff <= regWdata[`CTRL_LOOP];
      if (goRun)
        test_ff <= selTest;
      if (regWr && !busy_ff && regAddr == `OFS_LOADDR)
        lo_ff <= regWdata;
      if (regWr && !busy_ff && regAddr == `OFS_HIADDR)
        hi_ff <= regWdata;
      if (regWr && !busy_ff && regAddr == `OFS_MASK)
        mask_ff <= regWdata;
      if (regWr && !busy_ff && regAddr == `OFS_EXPSIG && !sigBad)
        expSig_ff <= regWdata[15:0];
    end
  end

  always_comb
  begin
    rdMux = 32'h00000000;
    unique case (regAddr)
      `OFS_CTRL: rdMux = {28'h0000000, loopEn_ff, test_ff, 1'b0};
      `OFS_LOADDR: rdMux = lo_ff;
      `OFS_HIADDR: rdMux = hi_ff;
      `OFS_MASK: rdMux = mask_ff;
      `OFS_EXPSIG: rdMux = {16'h0000, expSig_ff};
      `OFS_STAT: rdMux = {20'h00000, kind_ff, 1'b0, rej_ff, okEvt_ff, looping_ff,
                          errSeen_ff, pass_ff, done_ff, busy_ff};
      `OFS_ERRADDR: rdMux = eaddr_ff;
      `OFS_ERRWORD: rdMux = eword_ff;
      `OFS_SIGVAL: rdMux = {16'h0000, sigIf.sig};
      default: rdMux = 32'h00000000;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      regRdata_ff <= 32'h00000000;
    else
      regRdata_ff <= regRd ? rdMux : 32'h00000000;
  end

  assign regRdata = regRdata_ff;
  assign tgtAddr = tgtAddr_ff;
  assign tgtWdata = tgtWdata_ff;
  assign tgtWr = tgtWr_ff;
  assign tgtRd = tgtRd_ff;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);

  chk_io_word: assert property (repErr_ff && kind_ff == ERR_IO |-> eword_ff != 32'h0 && (eword_ff & ~mask_ff) == 32'h0)
    else $error("io error word outside mask");
  chk_rw_zero: assert property (repOk_ff && (kind_ff == ERR_IO || kind_ff == ERR_RAMRW) |-> eword_ff == 32'h0)
    else $error("cleared rw error word not zero");
  chk_rom_diff: assert property (repErr_ff && kind_ff == ERR_ROM |-> eword_ff[15:0] != expSig_ff)
    else $error("rom error with equal signatures");
  chk_rom_ok: assert property (repOk_ff && kind_ff == ERR_ROM |-> sigIf.sig == expSig_ff)
    else $error("rom ok with unequal signatures");
  chk_tied_pair: assert property (repErr_ff && kind_ff == ERR_TIED |-> eword_ff[4:0] < eword_ff[12:8])
    else $error("tied pair indices out of order");
  chk_td_base: assert property ((st_ff == S_TD_W1 || st_ff == S_TD_W2) && tgtWr_ff |-> tgtAddr_ff == lo_ff)
    else $error("tied test away from block base");
  chk_td_skip: assert property (st_ff == S_RW_CHK ##1 st_ff == S_TD_W1 |-> !unres_ff)
    else $error("tied phase ran with unresolved errors");
  chk_dc_skip: assert property (st_ff == S_TD_CHK ##1 st_ff == S_DC_SEL && bi_ff == 5'h00 |-> !unres_ff)
    else $error("decode phase ran with unresolved errors");
  chk_dc_addr: assert property (repErr_ff && kind_ff == ERR_DC |-> eaddr_ff[eword_ff[4:0]] == 1'b0)
    else $error("decode error address has bit set");
  chk_acc_hold: assert property ((tgtRd_ff || tgtWr_ff) && !tgtAck && !stopReq |=> $stable(tgtAddr_ff) && (tgtRd_ff || tgtWr_ff))
    else $error("target request dropped before ack");
  chk_acc_one: assert property (!(tgtRd_ff && tgtWr_ff))
    else $error("read and write at once");
  chk_done_flag: assert property ($fell(busy_ff) |-> done_ff)
    else $error("run ended without done");

  cov_io_err: cover property (repErr_ff && kind_ff == ERR_IO);
  cov_rom_ok: cover property (repOk_ff && kind_ff == ERR_ROM);
  cov_tied_err: cover property (repErr_ff && kind_ff == ERR_TIED);
  cov_dc_err: cover property (repErr_ff && kind_ff == ERR_DC);
endmodule : bus_memory_io_test_engine
`default_nettype wire

// ### testbench/tgt_mem_model.sv
// Target memory model: 64 words behind the request and acknowledge handshake.
// Assumes one held request at a time; the bench sets the fault inputs.
`default_nettype none
module tgt_mem_model (
  input wire logic core_clk,
  input wire logic [31:0] tgtAddr,
  input wire logic [31:0] tgtWdata,
  input wire logic tgtWr,
  input wire logic tgtRd,
  output logic tgtAck,
  output logic [31:0] tgtRdata,
  input wire logic [31:0] stuckLo,
  input wire logic [5:0] stuckAt,
  input wire logic tieEn,
  input wire logic [4:0] tieA,
  input wire logic [4:0] tieB,
  input wire logic [5:0] aliasMask
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [64];
  logic [31:0] w;
  logic [5:0] x;
  int gap;
  int pSeed;
  initial
  begin
    tgtAck = 1'b0;
    tgtRdata = 32'h3c3c5a5a;
    gap = 0;
    pSeed = 3;
  end
  // Random answer delay; data scrambled outside the ack cycle so stale reads show
  always @(posedge core_clk)
  begin
    x = tgtAddr[5:0] & ~aliasMask;
    w = tgtWdata;
    if ((tgtWr || tgtRd) && !tgtAck && gap > 0)
    begin
      gap = gap - 1;
      tgtAck <= 1'b0;
      tgtRdata <= ~tgtRdata;
    end
    else if ((tgtWr || tgtRd) && !tgtAck)
    begin
      gap = $unsigned($random(pSeed)) % 3;
      tgtAck <= 1'b1;
      // Wired-OR short between two data lines
      if (tieEn && (w[tieA] || w[tieB]))
        w = w | (32'h1 << tieA) | (32'h1 << tieB);
      if (tgtWr)
        mem[x] = w;
      tgtRdata <= (x == stuckAt) ? (mem[x] & ~stuckLo) : mem[x];
    end
    else
    begin
      tgtAck <= 1'b0;
      tgtRdata <= ~tgtRdata;
    end
  end
endmodule : tgt_mem_model
`default_nettype wire

// ### testbench/test_bus_memory_io_test_engine.sv
// Bench for the test engine: register tasks, fault scenarios, verdict.
// Assumes the target model and a 25 MHz core clock.
`include "bmt_regs.svh"
`default_nettype none
module test_bus_memory_io_test_engine;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, srst, regWr, regRd, tgtWr, tgtRd, tgtAck, tieEn;
  logic [7:0] regAddr;
  logic [31:0] regWdata, regRdata, tgtAddr, tgtWdata, tgtRdata, stuckLo, st, e, eb, sv;
  logic [31:0] shadow [16];
  logic [5:0] stuckAt, aliasMask;
  logic [4:0] tieA, tieB;
  int mismatches, total_checks, seed, i, a, b;
  bus_memory_io_test_engine u_dut (.core_clk(core_clk), .srst(srst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .tgtAddr(tgtAddr), .tgtWdata(tgtWdata), .tgtWr(tgtWr),
    .tgtRd(tgtRd), .tgtAck(tgtAck), .tgtRdata(tgtRdata));
  tgt_mem_model u_tgt (.core_clk(core_clk), .tgtAddr(tgtAddr), .tgtWdata(tgtWdata), .tgtWr(tgtWr), .tgtRd(tgtRd),
    .tgtAck(tgtAck), .tgtRdata(tgtRdata), .stuckLo(stuckLo), .stuckAt(stuckAt), .tieEn(tieEn), .tieA(tieA),
    .tieB(tieB), .aliasMask(aliasMask));
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  task automatic conclude;
    $display("Checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge core_clk);
    regAddr <= ad;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] ad, output logic [31:0] d);
    @(posedge core_clk);
    regAddr <= ad;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    @(negedge core_clk);
    d = regRdata;
  endtask : rd
  task automatic poll(input logic untilLoop);
    for (int n = 0; n < 20000; n++)
    begin
      rd(`OFS_STAT, st);
      if (st[`STAT_DONE] || st[`STAT_REJ] || (untilLoop && st[`STAT_LOOPING]))
        return;
    end
    mismatches++;
    conclude();
  endtask : poll
  task automatic run(input logic [31:0] lo, hi, opnd, ctrl);
    wr(`OFS_STAT, 32'h6a);
    wr(`OFS_LOADDR, lo);
    wr(`OFS_HIADDR, hi);
    wr(ctrl[2:1] == 2'h0 ? `OFS_MASK : `OFS_EXPSIG, opnd);
    wr(`OFS_CTRL, ctrl);
    poll(ctrl[`CTRL_LOOP]);
  endtask : run
  task automatic res(input logic [3:0] kind, input logic pass, input logic [31:0] ea, ew);
    logic [31:0] v;
    chk({31'h0, st[`STAT_PASS]}, {31'h0, pass});
    if (kind != 4'h0)
    begin
      chk({28'h0, st[`STAT_KIND]}, {28'h0, kind});
      rd(`OFS_ERRADDR, v);
      chk(v, ea);
      rd(`OFS_ERRWORD, v);
      chk(v, ew);
    end
    $display("Test ended, kind %0d", kind);
  endtask : res
  function automatic logic [31:0] sigOf();
    logic [15:0] s;
    s = 16'h0;
    for (int k = 0; k < 16; k++)
      for (int j = 31; j >= 0; j--)
        s = {s[14:0], 1'b0} ^ ((s[15] ^ shadow[k][j]) ? 16'h1021 : 16'h0);
    return {16'h0, s};
  endfunction : sigOf
  initial
  begin
    seed = 77593;
    {regWr, regRd, regAddr, regWdata, stuckLo, stuckAt, tieEn, tieA, tieB, aliasMask} = '0;
    {mismatches, total_checks} = '0;
    srst = 1'b1;
    for (i = 0; i < 64; i++)
      u_tgt.mem[i] = $random(seed);
    for (i = 0; i < 16; i++)
      shadow[i] = u_tgt.mem[16 + i];
    repeat (5) @(posedge core_clk);
    srst <= 1'b0;
    rd(`OFS_STAT, st);
    chk(st, 32'h0);
    rd(8'h24, st);
    chk(st, 32'h0);
    run(8, 11, $random(seed) | 1, 1);
    res(0, 1, 0, 0);
    stuckAt = 6'd9;
    stuckLo = 32'h101;
    run(8, 11, 32'hff, 1);
    res(1, 0, 9, 1);
    run(8, 11, 32'hff, 9);
    chk({31'h0, st[`STAT_LOOPING]}, 32'h1);
    stuckLo = 32'h0;
    poll(1'b0);
    res(1, 1, 9, 0);
    chk({31'h0, st[`STAT_OK]}, 32'h1);
    for (i = 0; i < 3; i++)
    begin
      run(8, i == 1 ? 7 : 11, 0, i == 0 ? 1 : i == 1 ? 5 : 7);
      chk({30'h0, st[`STAT_REJ], st[`STAT_BUSY]}, 32'h2);
    end
    wr(`OFS_STAT, 32'h6a);
    wr(`OFS_EXPSIG, 32'h10000);
    rd(`OFS_STAT, st);
    chk({31'h0, st[`STAT_REJ]}, 32'h1);
    e = sigOf();
    run(16, 31, e, 3);
    res(0, 1, 0, 0);
    rd(`OFS_SIGVAL, sv);
    chk(sv, e);
    run(16, 31, e ^ 32'h1, 3);
    res(2, 0, 16, e);
    // Corrupt one ROM word, loop on it, then repair it while the engine recomputes
    shadow[4] = shadow[4] ^ 32'h1;
    eb = sigOf();
    shadow[4] = shadow[4] ^ 32'h1;
    u_tgt.mem[20] = u_tgt.mem[20] ^ 32'h1;
    run(16, 31, e, 11);
    chk({31'h0, st[`STAT_LOOPING]}, 32'h1);
    u_tgt.mem[20] = u_tgt.mem[20] ^ 32'h1;
    poll(1'b0);
    res(2, 1, 16, eb);
    rd(`OFS_SIGVAL, sv);
    chk(sv, e);
    run(32, 63, 0, 5);
    res(0, 1, 0, 0);
    stuckAt = 6'd37;
    stuckLo = 32'h80000000;
    run(32, 63, 0, 5);
    res(3, 0, 37, 32'h80000000);
    stuckLo = 32'h0;
    a = $unsigned($random(seed)) % 31;
    b = a + 1 + $unsigned($random(seed)) % (31 - a);
    {tieEn, tieA, tieB} = {1'b1, 5'(a), 5'(b)};
    run(32, 63, 0, 5);
    res(4, 0, 32, {19'h0, tieB, 3'h0, tieA});
    run(32, 63, 0, 13);
    chk({31'h0, st[`STAT_LOOPING]}, 32'h1);
    tieEn = 1'b0;
    poll(1'b0);
    res(4, 1, 32, {19'h0, tieB, 3'h0, tieA});
    chk({31'h0, st[`STAT_OK]}, 32'h1);
    a = $unsigned($random(seed)) % 5;
    aliasMask = 6'(1 << a);
    run(32, 63, 0, 5);
    res(5, 0, 32, 32'(a));
    run(32, 63, 0, 13);
    chk({31'h0, st[`STAT_LOOPING]}, 32'h1);
    aliasMask = 6'h00;
    poll(1'b0);
    res(5, 1, 32, 32'(a));
    // Stop in mid-run must end the run with a fail verdict
    wr(`OFS_STAT, 32'h6a);
    wr(`OFS_CTRL, 32'h5);
    wr(`OFS_CTRL, 32'h10);
    poll(1'b0);
    chk({30'h0, st[`STAT_DONE], st[`STAT_BUSY]}, 32'h2);
    res(0, 0, 0, 0);
    conclude();
  end
endmodule : test_bus_memory_io_test_engine
`default_nettype wire
